// ### core/battery_backed_rtc_sram.sv
`timescale 1ns/1ps
`include "rtc_sram_defines.svh"
`default_nettype none

module battery_backed_rtc_sram #(
    parameter int unsigned TICK_CYCLES = `ONE_SEC_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Host bus
    input wire rtc_sram_pkg::sram_bus_t sramBus,
    output logic [7:0] dataOut,
    output logic dataOe,
    // Supply monitor
    input wire logic powerFail,
    input wire logic belowSwitchover,
    output logic batteryOn
);
    import rtc_sram_pkg::*;

    localparam int unsigned REC_CYCLES =
        (`REC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    logic [7:0] ram [0:32767];
    bus_state_t busState_q;
    logic [14:0] wrAddr_q;
    logic [7:0] wrData_q;
    logic [31:0] recCnt_q;
    logic [31:0] presc_q;
    logic tick_q;
    logic [7:0] ctrlReg_q;
    time_t tReg_q;
    time_t cnt_q;
    logic [7:0] dataOut_q;
    logic dataOe_q;
    logic batteryOn_q;
    logic accessOk;
    logic commit;
    logic freeze;
    logic haltOsc;
    time_t nextCnt;

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcdInc

    // Leap test works on BCD digits directly, valid for 00-99
    function automatic logic [7:0] lastDate(input logic [7:0] mon,
                                            input logic [7:0] yr);
        logic leap;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                yr[3:0] == 4'h8)) ||
               (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        case (mon)
            8'h02: lastDate = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: lastDate = 8'h30;
            default: lastDate = 8'h31;
        endcase
    endfunction : lastDate

    // One second step of the true counters
    function automatic time_t advance(input time_t c, input logic cenEn);
        time_t n;
        n = c;
        n.seconds = {1'b0, c.seconds[6:0]};
        if (c.seconds[6:0] != 7'h59) begin
            n.seconds = bcdInc(n.seconds);
        end else begin
            n.seconds = 8'h00;
            if (c.minutes != 8'h59) begin
                n.minutes = bcdInc(c.minutes);
            end else begin
                n.minutes = 8'h00;
                if (c.hours != 8'h23) begin
                    n.hours = bcdInc(c.hours);
                end else begin
                    n.hours = 8'h00;
                    if (c.dayCent[2:0] == 3'h7) begin
                        n.dayCent[2:0] = 3'h1;
                    end else begin
                        n.dayCent[2:0] = c.dayCent[2:0] + 3'h1;
                    end
                    if (c.date != lastDate(c.month, c.year)) begin
                        n.date = bcdInc(c.date);
                    end else begin
                        n.date = 8'h01;
                        if (c.month != 8'h12) begin
                            n.month = bcdInc(c.month);
                        end else begin
                            n.month = 8'h01;
                            if (c.year != 8'h99) begin
                                n.year = bcdInc(c.year);
                            end else begin
                                n.year = 8'h00;
                                if (cenEn) begin
                                    n.dayCent[`CENT_FLAG_BIT] =
                                        !c.dayCent[`CENT_FLAG_BIT];
                                end
                            end
                        end
                    end
                end
            end
        end
        advance = n;
    endfunction : advance

    // Fresh counts into the visible bytes; user-owned bits are kept
    function automatic time_t copyOut(input time_t r, input time_t c);
        time_t o;
        o = c;
        o.seconds[`HALT_OSC_BIT] = r.seconds[`HALT_OSC_BIT];
        o.dayCent[7:5] = r.dayCent[7:5];
        o.dayCent[3] = r.dayCent[3];
        copyOut = o;
    endfunction : copyOut

    function automatic logic [7:0] readByte(input logic [14:0] a,
                                            input logic [7:0] ramByte,
                                            input logic [7:0] ctrl,
                                            input time_t r);
        case (a)
            `CTRL_ADDR: readByte = ctrl;
            `SEC_ADDR: readByte = r.seconds;
            `MIN_ADDR: readByte = r.minutes;
            `HOUR_ADDR: readByte = r.hours;
            `DAY_ADDR: readByte = r.dayCent;
            `DATE_ADDR: readByte = r.date;
            `MONTH_ADDR: readByte = r.month;
            `YEAR_ADDR: readByte = r.year;
            default: readByte = ramByte;
        endcase
    endfunction : readByte

    assign accessOk = !powerFail && (recCnt_q == 32'h0000_0000);
    assign commit = (busState_q == BUS_WRITE) && !powerFail &&
                    (sramBus.chipEnN || sramBus.writeEnN);
    assign freeze = ctrlReg_q[`CTRL_WRITE_BIT] || ctrlReg_q[`CTRL_READ_BIT];
    assign haltOsc = tReg_q.seconds[`HALT_OSC_BIT];
    assign nextCnt = advance(cnt_q, tReg_q.dayCent[`CENT_EN_BIT]);

    // Recovery lockout after the supply comes back
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            recCnt_q <= REC_CYCLES;
        end else if (powerFail) begin
            recCnt_q <= REC_CYCLES;
        end else if (recCnt_q != 32'h0000_0000) begin
            recCnt_q <= recCnt_q - 32'h0000_0001;
        end
    end

    // Write cycle tracking; data is taken on the last cycle before the end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_q <= BUS_IDLE;
            wrAddr_q <= 15'h0000;
            wrData_q <= 8'h00;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (accessOk && !sramBus.chipEnN &&
                        !sramBus.writeEnN) begin
                        busState_q <= BUS_WRITE;
                        wrAddr_q <= sramBus.addr;
                        wrData_q <= sramBus.data;
                    end
                end
                BUS_WRITE: begin
                    if (powerFail) begin
                        busState_q <= BUS_IDLE;
                    end else if (commit) begin
                        busState_q <= BUS_IDLE;
                    end else begin
                        wrData_q <= sramBus.data;
                    end
                end
                default: busState_q <= BUS_IDLE;
            endcase
        end
    end

    // Plain array; an aborted write never reaches it
    always_ff @(posedge core_clk) begin
        if (commit && wrAddr_q < `CLK_BASE_ADDR) begin
            ram[wrAddr_q] <= wrData_q;
        end
    end

    // Prescaler, true counters and visible clock bytes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_q <= 32'h0000_0000;
            tick_q <= 1'b0;
            ctrlReg_q <= `CTRL_RST;
            tReg_q <= {`YEAR_RST, `MONTH_RST, `DATE_RST, `DAY_RST,
                       `HOUR_RST, `MIN_RST, `SEC_RST};
            cnt_q <= {`YEAR_RST, `MONTH_RST, `DATE_RST, `DAY_RST,
                      `HOUR_RST, `MIN_RST, 8'h00};
        end else begin
            tick_q <= 1'b0;
            if (haltOsc) begin
                presc_q <= 32'h0000_0000;
            end else if (presc_q == TICK_CYCLES - 1) begin
                presc_q <= 32'h0000_0000;
                tick_q <= 1'b1;
            end else begin
                presc_q <= presc_q + 32'h0000_0001;
            end
            // Counters run on battery too, so only the tick gates them
            if (tick_q) begin
                cnt_q <= nextCnt;
            end
            // Single-cycle copy: a freeze landing now takes effect after
            if (tick_q && !freeze) begin
                tReg_q <= copyOut(tReg_q, nextCnt);
            end
            if (powerFail) begin
                tReg_q.dayCent[`FREQ_TEST_BIT] <= 1'b0;
            end
            if (commit) begin
                case (wrAddr_q)
                    `CTRL_ADDR: begin
                        ctrlReg_q <= wrData_q;
                        if (ctrlReg_q[`CTRL_WRITE_BIT] &&
                            !wrData_q[`CTRL_WRITE_BIT]) begin
                            cnt_q <= tReg_q;
                            cnt_q.seconds[`HALT_OSC_BIT] <= 1'b0;
                            presc_q <= 32'h0000_0000;
                        end
                    end
                    `SEC_ADDR: tReg_q.seconds <= wrData_q;
                    `MIN_ADDR: tReg_q.minutes <= wrData_q;
                    `HOUR_ADDR: tReg_q.hours <= wrData_q;
                    `DAY_ADDR: begin
                        tReg_q.dayCent[7:5] <= wrData_q[7:5];
                        tReg_q.dayCent[3:0] <= wrData_q[3:0];
                        if (ctrlReg_q[`CTRL_WRITE_BIT]) begin
                            tReg_q.dayCent[`CENT_FLAG_BIT] <=
                                wrData_q[`CENT_FLAG_BIT];
                        end else begin
                            tReg_q.dayCent[`CENT_FLAG_BIT] <=
                                tReg_q.dayCent[`CENT_FLAG_BIT];
                        end
                    end
                    `DATE_ADDR: tReg_q.date <= wrData_q;
                    `MONTH_ADDR: tReg_q.month <= wrData_q;
                    `YEAR_ADDR: tReg_q.year <= wrData_q;
                    default: ;
                endcase
            end
        end
    end

    // Output drive; a write in flight or pending never drives
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataOe_q <= 1'b0;
            dataOut_q <= 8'h00;
        end else begin
            dataOe_q <= accessOk && !sramBus.chipEnN && !sramBus.outEnN &&
                        sramBus.writeEnN && (busState_q == BUS_IDLE);
            dataOut_q <= readByte(sramBus.addr, ram[sramBus.addr],
                                  ctrlReg_q, tReg_q);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            batteryOn_q <= 1'b0;
        end else begin
            batteryOn_q <= belowSwitchover;
        end
    end

    assign dataOut = dataOut_q;
    assign dataOe = dataOe_q;
    assign batteryOn = batteryOn_q;

    default clocking assertClk @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence wrDone_s;
        commit && (wrAddr_q < `CLK_BASE_ADDR);
    endsequence

    pf_float_a:
        assert property (powerFail |=> !dataOe)
        else $error("outputs driven during power fail");

    we_float_a:
        assert property (!sramBus.writeEnN |=> !dataOe)
        else $error("outputs driven with write enable low");

    same_fall_a:
        assert property ((sramBus.chipEnN && sramBus.writeEnN) ##1
                         (!sramBus.chipEnN && !sramBus.writeEnN)
                         |=> !dataOe)
        else $error("outputs driven on joint enable fall");

    ram_store_a:
        assert property (wrDone_s |=> ram[$past(wrAddr_q)] ==
                         $past(wrData_q))
        else $error("write data not stored");

    rec_lock_a:
        assert property ($fell(powerFail) |-> !accessOk ##1 !accessOk)
        else $error("access allowed before recovery");

    freeze_hold_a:
        assert property ((freeze && !commit && !powerFail) |=>
                         $stable(tReg_q))
        else $error("frozen clock bytes changed");

    tick_copy_a:
        assert property ((tick_q && !freeze && !commit) |=>
                         tReg_q.minutes == cnt_q.minutes &&
                         tReg_q.seconds[6:0] == cnt_q.seconds[6:0])
        else $error("clock bytes not refreshed");

    halt_stop_a:
        assert property (haltOsc |=> !tick_q)
        else $error("tick while oscillator halted");

    century_guard_a:
        assert property ((commit && wrAddr_q == `DAY_ADDR && !tick_q &&
                          !ctrlReg_q[`CTRL_WRITE_BIT]) |=>
                         $stable(tReg_q.dayCent[`CENT_FLAG_BIT]))
        else $error("century flag written without write bit");

    load_cnt_a:
        assert property ((commit && wrAddr_q == `CTRL_ADDR &&
                          ctrlReg_q[`CTRL_WRITE_BIT] &&
                          !wrData_q[`CTRL_WRITE_BIT]) |=>
                         cnt_q.hours == $past(tReg_q.hours) &&
                         presc_q == 32'h0000_0000)
        else $error("counters not loaded on write bit clear");

    batt_follow_a:
        assert property (batteryOn == $past(belowSwitchover))
        else $error("battery switch does not follow level");

endmodule : battery_backed_rtc_sram

`default_nettype wire

// ### core/rtc_sram_defines.svh
`ifndef RTC_SRAM_DEFINES_SVH
`define RTC_SRAM_DEFINES_SVH

// Clock byte addresses
`define CLK_BASE_ADDR 15'h7FF8
`define CTRL_ADDR 15'h7FF8
`define SEC_ADDR 15'h7FF9
`define MIN_ADDR 15'h7FFA
`define HOUR_ADDR 15'h7FFB
`define DAY_ADDR 15'h7FFC
`define DATE_ADDR 15'h7FFD
`define MONTH_ADDR 15'h7FFE
`define YEAR_ADDR 15'h7FFF

// Field positions
`define CTRL_WRITE_BIT 7
`define CTRL_READ_BIT 6
`define HALT_OSC_BIT 7
`define FREQ_TEST_BIT 6
`define CENT_EN_BIT 5
`define CENT_FLAG_BIT 4

// Reset values
`define CTRL_RST 8'h00
`define SEC_RST 8'h80
`define MIN_RST 8'h00
`define HOUR_RST 8'h00
`define DAY_RST 8'h01
`define DATE_RST 8'h01
`define MONTH_RST 8'h01
`define YEAR_RST 8'h00

// Timing
`define CLK_PERIOD_NS 8
`define ONE_SEC_NS 1000000000
`define REC_TIME_NS 1000

`endif

// ### core/rtc_sram_pkg.sv
package rtc_sram_pkg;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] dayCent;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } time_t;

    typedef struct packed {
        logic chipEnN;
        logic outEnN;
        logic writeEnN;
        logic [14:0] addr;
        logic [7:0] data;
    } sram_bus_t;

    typedef enum logic {BUS_IDLE, BUS_WRITE} bus_state_t;

endpackage : rtc_sram_pkg

// ### tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    // Clock
    input wire logic core_clk,
    // Host bus
    output var rtc_sram_pkg::sram_bus_t sramBus
);
    import rtc_sram_pkg::*;

    // Released lines flip so that a stale value can never pass for data
    task automatic idle();
        sramBus.chipEnN = 1'b1;
        sramBus.writeEnN = 1'b1;
        sramBus.outEnN = 1'b1;
        sramBus.addr = ~sramBus.addr;
        sramBus.data = ~sramBus.data;
    endtask : idle

    initial begin
        sramBus = '0;
        idle();
    end

    // Enables fall together; address held until both are high again
    task automatic busWrite(input logic [14:0] a, input logic [7:0] d,
                            input bit oeLow);
        @(posedge core_clk);
        #1;
        sramBus.addr = a;
        sramBus.data = d;
        sramBus.outEnN = !oeLow;
        sramBus.chipEnN = 1'b0;
        sramBus.writeEnN = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        idle();
    endtask : busWrite

    // One-cycle read; optionally write enable then falls with output on
    task automatic busRead(input logic [14:0] a, input bit weAfter,
                           input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sramBus.addr = a;
        sramBus.outEnN = 1'b0;
        sramBus.writeEnN = 1'b1;
        sramBus.chipEnN = 1'b0;
        @(posedge core_clk);
        #1;
        if (weAfter) begin
            sramBus.data = d;
            sramBus.writeEnN = 1'b0;
            repeat (2) @(posedge core_clk);
            #1;
        end
        idle();
    endtask : busRead
endmodule : host_bus_model

`default_nettype wire

// ### tb/test_battery_backed_rtc_sram.sv
`timescale 1ns/1ps
`include "rtc_sram_defines.svh"
`default_nettype none

module test_battery_backed_rtc_sram;
    import rtc_sram_pkg::*;

    // Short second keeps the run small
    localparam int TICKS = 20;
    localparam logic [7:0] SET_T [7] = '{8'h59, 8'h59, 8'h23, 8'h31,
                                         8'h31, 8'h12, 8'h99};
    localparam logic [7:0] ROLL_T [7] = '{8'h00, 8'h00, 8'h00, 8'h22,
                                          8'h01, 8'h01, 8'h00};

    logic core_clk;
    logic sys_rst;
    logic powerFail;
    logic belowSwitchover;
    sram_bus_t sramBus;
    logic [7:0] dataOut;
    logic dataOe;
    logic batteryOn;
    int mismatches = 0;
    int checksDone = 0;
    int seed = 8;
    logic [7:0] expQ [$];
    logic [14:0] ramA [8];
    logic [7:0] ramD [8];

    battery_backed_rtc_sram #(.TICK_CYCLES(TICKS)) DUT (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sramBus(sramBus),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .powerFail(powerFail),
        .belowSwitchover(belowSwitchover),
        .batteryOn(batteryOn)
    );

    host_bus_model host (
        .core_clk(core_clk),
        .sramBus(sramBus)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic expectRead(input logic [14:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        host.busRead(a, 1'b0, 8'h00);
    endtask : expectRead

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles

    // Any drive with no read pending is a fault: refused or overlapped access
    always @(negedge core_clk) begin
        if (!sys_rst && dataOe === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unexpected drive", 8'h01, 8'h00);
            end else begin
                check("read data", dataOut, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        powerFail = 1'b0;
        belowSwitchover = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        cycles(130);
        for (int i = 0; i < 8; i++) begin
            ramA[i] = {1'b0, 3'(i), 11'($random(seed))};
            ramD[i] = 8'($random(seed));
            host.busWrite(ramA[i], ramD[i], 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            expectRead(ramA[i], ramD[i]);
        end
        $display("test ram done");
        expQ.push_back(ramD[0]);
        ramD[0] = 8'h5a;
        host.busRead(ramA[0], 1'b1, ramD[0]);
        ramD[1] = 8'ha5;
        host.busWrite(ramA[1], ramD[1], 1'b1);
        expectRead(ramA[0], ramD[0]);
        expectRead(ramA[1], ramD[1]);
        $display("test overlap done");
        powerFail = 1'b1;
        host.busWrite(ramA[2], ~ramD[2], 1'b0);
        host.busRead(ramA[2], 1'b0, 8'h00);
        powerFail = 1'b0;
        host.busWrite(ramA[2], ~ramD[2], 1'b0);
        cycles(130);
        expectRead(ramA[2], ramD[2]);
        fork
            host.busWrite(ramA[3], ~ramD[3], 1'b0);
            begin
                cycles(2);
                powerFail = 1'b1;
            end
        join
        cycles(1);
        powerFail = 1'b0;
        cycles(130);
        // An aborted write stores nothing, so the old byte stays
        expectRead(ramA[3], ramD[3]);
        expectRead(ramA[2], ramD[2]);
        expectRead(ramA[4], ramD[4]);
        $display("test powerfail done");
        belowSwitchover = 1'b1;
        cycles(2);
        check("battery on", {7'h00, batteryOn}, 8'h01);
        belowSwitchover = 1'b0;
        cycles(2);
        check("battery off", {7'h00, batteryOn}, 8'h00);
        $display("test battery done");
        expectRead(`SEC_ADDR, 8'h80);
        host.busWrite(`DAY_ADDR, 8'h31, 1'b0);
        expectRead(`DAY_ADDR, 8'h21);
        host.busWrite(`CTRL_ADDR, 8'ha5, 1'b0);
        expectRead(`CTRL_ADDR, 8'ha5);
        // Reserved bits and the test bit always written as zero
        for (int i = 0; i < 7; i++) begin
            host.busWrite(`SEC_ADDR + 15'(i), SET_T[i], 1'b0);
        end
        expectRead(`DAY_ADDR, 8'h31);
        host.busWrite(`CTRL_ADDR, 8'h25, 1'b0);
        // One tick lands before the freeze, the next ones are held off
        cycles(22);
        host.busWrite(`CTRL_ADDR, 8'h65, 1'b0);
        cycles(45);
        for (int i = 0; i < 7; i++) begin
            expectRead(`SEC_ADDR + 15'(i), ROLL_T[i]);
        end
        expectRead(`CTRL_ADDR, 8'h65);
        $display("test clock done");
        // Non-leap February: the 28th rolls over to the 1st of March
        host.busWrite(`CTRL_ADDR, 8'h80, 1'b0);
        for (int i = 0; i < 3; i++) begin
            host.busWrite(`SEC_ADDR + 15'(i), SET_T[i], 1'b0);
        end
        host.busWrite(`DATE_ADDR, 8'h28, 1'b0);
        host.busWrite(`MONTH_ADDR, 8'h02, 1'b0);
        host.busWrite(`YEAR_ADDR, 8'h01, 1'b0);
        host.busWrite(`CTRL_ADDR, 8'h00, 1'b0);
        cycles(22);
        host.busWrite(`CTRL_ADDR, 8'h40, 1'b0);
        expectRead(`DATE_ADDR, 8'h01);
        expectRead(`MONTH_ADDR, 8'h03);
        $display("test february done");
        for (int i = 0; i < 10 && expQ.size() != 0; i++) begin
            cycles(1);
        end
        if (expQ.size() != 0) begin
            check("pending reads", 8'(expQ.size()), 8'h00);
        end
        tally_and_finish();
    end
endmodule : test_battery_backed_rtc_sram

`default_nettype wire
